// [bench/testbench.sv]
/*
 * Testbench for the page walker: registers over AXI4-Lite, then walks.
 * Assumes the memory model answers every entry access.
 */
`timescale 1ns/1ps
module testbench;
	localparam logic [31:0] VA = 32'h1234_5678;
	localparam logic [31:0] BASE = 32'h0001_0000;
	logic        sys_clk_i, rst_i, req_valid_i, req_write_i, req_instr_i, req_user_i, req_locked_i;
	logic        req_ready_o, resp_valid_o, resp_fault_data_o, resp_fault_instr_o, mem_ready_i;
	logic        page_cache_inhibit_out_o, page_write_through_out_o, mem_valid_o, mem_write_o;
	logic        mem_lock_o, mem_uncached_o, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] req_vaddr_i, resp_paddr_o, mem_addr_o, mem_wdata_o, mem_rdata_i, s_axi_wdata, s_axi_rdata;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [2:0]  lat;
	int          failures = 0;
	int          cmp_count = 0;

	tpw_walker tpw_walker_inst (.*);
	tpw_mem_model tpw_mem_model_inst (.sys_clk_i(sys_clk_i), .wait_i(lat), .valid_i(mem_valid_o),
		.ready_o(mem_ready_i), .write_i(mem_write_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o),
		.rdata_o(mem_rdata_i));

	// Clock
	initial
	begin
		sys_clk_i = 1'b0;
		forever #12.5 sys_clk_i = ~sys_clk_i;
	end

	////////////////////////////////////////////////////////////////////////
	task report_and_stop;
		if (failures == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] s, e);
		cmp_count++;
		if (s !== e)
		begin
			failures++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask

	// A used-up wait counts as a mismatch and ends the run
	task tmo(input bit t);
		if (t)
		begin
			failures++;
			report_and_stop();
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic aw, w;
		begin
			@(posedge sys_clk_i);
			{aw, w} = 2'h3;
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
			for (n = 0; n < 50; n++)
			begin
				@(posedge sys_clk_i);
				if (s_axi_awready === 1'b1)
					aw = 1'b0;
				if (s_axi_wready === 1'b1)
					w = 1'b0;
				s_axi_awvalid <= aw;
				s_axi_wvalid <= w;
				if (s_axi_bvalid === 1'b1)
					break;
			end
			s_axi_bready <= 1'b0;
			tmo(n == 50);
			chk("bresp", s_axi_bresp, er);
		end
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		logic ar;
		begin
			@(posedge sys_clk_i);
			ar = 1'b1;
			s_axi_araddr <= a;
			{s_axi_arvalid, s_axi_rready} <= 2'h3;
			for (n = 0; n < 50; n++)
			begin
				@(posedge sys_clk_i);
				if (s_axi_arready === 1'b1)
					ar = 1'b0;
				s_axi_arvalid <= ar;
				if (!ar && s_axi_rvalid === 1'b1)
					break;
			end
			s_axi_rready <= 1'b0;
			tmo(n == 50);
			chk("rresp", s_axi_rresp, er);
			chk("rdata", s_axi_rdata, ed);
		end
	endtask

	// One walk; f is write, instr, user, locked, write-protect
	task automatic walk(input logic [31:0] de, te, input logic [4:0] f, input logic [1:0] ef);
		logic [31:0] da, ta;
		int n;
		begin
			da = BASE + {VA[31:22], 2'h0};
			ta = {de[31:12], VA[21:12], 2'h0};
			axi_wr(8'h04, {31'h0, f[0]}, tpw_pkg::RESP_OKAY);
			tpw_mem_model_inst.mem[da] = de;
			tpw_mem_model_inst.mem[ta] = te;
			req_vaddr_i <= VA;
			{req_write_i, req_instr_i, req_user_i, req_locked_i} <= f[4:1];
			req_valid_i <= 1'b1;
			@(posedge sys_clk_i);
			chk("ready", req_ready_o, 1'b1);
			req_valid_i <= 1'b0;
			for (n = 0; n < 300 && resp_valid_o !== 1'b1; n++)
				@(posedge sys_clk_i);
			tmo(n == 300);
			chk("fault", {resp_fault_data_o, resp_fault_instr_o}, ef);
			@(posedge sys_clk_i);
			if (ef != 2'h0)
				chk("dir_kept", tpw_mem_model_inst.mem[da], de);
			else if (de[7])
			begin
				chk("paddr", resp_paddr_o, {de[31:22], VA[21:0]});
				chk("pins", {page_cache_inhibit_out_o, page_write_through_out_o}, de[4:3]);
				chk("dir_a", tpw_mem_model_inst.mem[da], de | 32'h20);
			end
			else
			begin
				chk("paddr", resp_paddr_o, {te[31:12], VA[11:0]});
				chk("pins", {page_cache_inhibit_out_o, page_write_through_out_o}, te[4:3]);
				chk("dir_a", tpw_mem_model_inst.mem[da], de | 32'h20);
				chk("tbl_a", tpw_mem_model_inst.mem[ta], te | 32'h20);
			end
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		{req_valid_i, req_write_i, req_instr_i, req_user_i, req_locked_i} = 5'h00;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{req_vaddr_i, s_axi_wdata, s_axi_awaddr, s_axi_araddr} = 80'h0;
		s_axi_wstrb = 4'hf;
		lat = 3'h0;
		rst_i = 1'b1;
		repeat (5) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		axi_rd(8'h00, tpw_pkg::RST_DIRBASE, tpw_pkg::RESP_OKAY);
		axi_wr(8'h00, BASE | 32'h0abc, tpw_pkg::RESP_OKAY);
		axi_rd(8'h00, BASE, tpw_pkg::RESP_OKAY);
		axi_wr(8'h10, 32'h1, tpw_pkg::RESP_SLVERR);
		axi_rd(8'h10, 32'h0, tpw_pkg::RESP_SLVERR);
		walk(32'hc000_00b7, 32'h0, 5'h00, 2'h0);
		axi_rd(8'h0c, 32'hc034_5678, tpw_pkg::RESP_OKAY);
		walk(32'h8040_008f, 32'h0, 5'h00, 2'h0);
		lat <= 3'h2;
		walk(32'h0005_0017, 32'h0aaa_a04f, 5'h14, 2'h0);
		walk(32'hffff_fffe, 32'h0, 5'h08, 2'h1);
		walk(32'h0000_00e5, 32'h0, 5'h11, 2'h2);
		axi_rd(8'h04, 32'h1, tpw_pkg::RESP_OKAY);
		walk(32'h0000_00e5, 32'h0, 5'h10, 2'h0);
		walk(32'h0000_00e3, 32'h0, 5'h0c, 2'h1);
		walk(32'h0000_0087, 32'h0, 5'h02, 2'h2);
		lat <= 3'h0;
		walk(32'h0000_00a7, 32'h0, 5'h10, 2'h2);
		walk(32'h0005_0067, 32'h0aaa_a027, 5'h10, 2'h2);
		walk(32'h0005_0027, 32'h0aaa_a067, 5'h10, 2'h0);
		walk(32'h0005_0065, 32'h0aaa_a067, 5'h14, 2'h2);
		walk(32'h0005_0027, 32'h0aaa_a007, 5'h02, 2'h2);
		chk("lock_kept", mem_lock_o, 1'b1);
		axi_rd(8'h08, 32'h0000_000a, tpw_pkg::RESP_OKAY);
		walk(32'h0005_0027, 32'h0aaa_a027, 5'h02, 2'h0);
		report_and_stop();
	end
endmodule // testbench

// [bench/tpw_mem_model.sv]
/*
 * External memory holding directory and table entries.
 * Assumes the walker holds valid, address and data until ready.
 */
`timescale 1ns/1ps
module tpw_mem_model (
	// Clock and answer delay
	input wire logic        sys_clk_i,
	input wire logic [2:0]  wait_i,
	// Walker memory port
	input wire logic        valid_i,
	output logic            ready_o,
	input wire logic        write_i,
	input wire logic [31:0] addr_i,
	input wire logic [31:0] wdata_i,
	output logic [31:0]     rdata_o
);
	logic [31:0] mem [logic [31:0]];
	logic [2:0]  cnt_q = 3'h0;
	logic [31:0] last_q = 32'h0;

	// Answer after wait_i cycles; the data line shows garbage outside an answer
	assign ready_o = valid_i && (cnt_q == wait_i);
	always_comb
		rdata_o = (ready_o && !write_i && mem.exists(addr_i)) ? mem[addr_i] : ~last_q;

	// Words stored with byte 0 in bits 7:0
	always @(posedge sys_clk_i)
	begin
		cnt_q <= (valid_i && !ready_o) ? cnt_q + 3'h1 : 3'h0;
		if (ready_o && !write_i)
			last_q <= rdata_o;
		if (ready_o && write_i)
			mem[addr_i] = wdata_i;
	end
endmodule // tpw_mem_model

// [bench/tpw_monitor.sv]
/*
 * Port checker for the page walker: walk start, write-back, lock, faults.
 * Assumes it is bound to tpw_walker and that all ports share sys_clk_i.
 */
`timescale 1ns/1ps
module tpw_monitor (
	// Clock, reset and request
	input wire logic        sys_clk_i,
	input wire logic        rst_i,
	input wire logic        req_valid_i,
	input wire logic        req_ready_o,
	input wire logic [31:0] req_vaddr_i,
	input wire logic        req_instr_i,
	input wire logic        req_locked_i,
	// Answer
	input wire logic        resp_valid_o,
	input wire logic [31:0] resp_paddr_o,
	input wire logic        resp_fault_data_o,
	input wire logic        resp_fault_instr_o,
	input wire logic        page_cache_inhibit_out_o,
	// Memory port
	input wire logic        mem_valid_o,
	input wire logic        mem_ready_i,
	input wire logic        mem_write_o,
	input wire logic [31:0] mem_addr_o,
	input wire logic [31:0] mem_wdata_o,
	input wire logic        mem_lock_o,
	input wire logic        mem_uncached_o
);
	logic [31:0] va_q;
	logic        ins_q;
	logic        lk_q;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	sequence take_s; req_valid_i && req_ready_o; endsequence
	sequence wb_s; mem_valid_o && mem_write_o && mem_ready_i; endsequence

	// Request attributes kept for the walk, since the core drops them after take
	always_ff @(posedge sys_clk_i)
	begin
		if (req_valid_i && req_ready_o)
		begin
			va_q  <= req_vaddr_i;
			ins_q <= req_instr_i;
			lk_q  <= req_locked_i;
		end
	end

	uncached_a: assert property (mem_uncached_o == mem_valid_o) else $error("entry access cached");
	fault_gate_a: assert property (!resp_valid_o |-> !resp_fault_data_o && !resp_fault_instr_o)
		else $error("fault outside answer");
	dir_addr_a: assert property (take_s |=> mem_valid_o && !mem_write_o && mem_addr_o[11:0] == {va_q[31:22], 2'h0})
		else $error("bad first entry address");
	wb_lock_a: assert property (mem_valid_o && mem_write_o |-> mem_lock_o) else $error("unlocked write-back");
	wb_flag_a: assert property (mem_valid_o && mem_write_o |-> mem_wdata_o[5]) else $error("accessed not set");
	wb_unlock_a: assert property (wb_s |=> ##[0:2] !mem_lock_o) else $error("lock kept after write-back");
	offset_a: assert property (resp_valid_o && !resp_fault_data_o && !resp_fault_instr_o |->
		resp_paddr_o[11:0] == va_q[11:0]) else $error("page offset lost");
	instr_fault_a: assert property (resp_fault_instr_o |-> ins_q) else $error("instr fault on data");
	lock_nowb_a: assert property (lk_q && !req_ready_o |-> !(mem_valid_o && mem_write_o))
		else $error("flag set in locked sequence");
	walk_end_a: assert property (take_s |-> ##[3:200] resp_valid_o) else $error("walk never ends");
	pin_hold_a: assert property (resp_valid_o && (resp_fault_data_o || resp_fault_instr_o) |->
		$stable(page_cache_inhibit_out_o)) else $error("pin moved on fault");
endmodule // tpw_monitor

bind tpw_walker tpw_monitor tpw_monitor_inst (.sys_clk_i, .rst_i, .req_valid_i, .req_ready_o, .req_vaddr_i,
	.req_instr_i, .req_locked_i, .resp_valid_o, .resp_paddr_o, .resp_fault_data_o, .resp_fault_instr_o,
	.page_cache_inhibit_out_o, .mem_valid_o, .mem_ready_i, .mem_write_o, .mem_addr_o, .mem_wdata_o,
	.mem_lock_o, .mem_uncached_o);

// [rtl/tpw_pkg.sv]
/*
 * Shared constants of the two-level page walker: register map, entry
 * field positions, virtual address split, bus answers and walk states.
 * Assumes a 32-bit physical space and 32-bit little-endian table entries.
 */
package tpw_pkg;

	// Register byte offsets on the AXI4-Lite slave
	localparam logic [7:0] OFS_DIRBASE = 8'h00;
	localparam logic [7:0] OFS_CTRL    = 8'h04;
	localparam logic [7:0] OFS_STATUS  = 8'h08;
	localparam logic [7:0] OFS_PADDR   = 8'h0c;

	// Reset values
	localparam logic [31:0] RST_DIRBASE = 32'h0000_0000;
	localparam logic        RST_WP      = 1'b0;

	// Control and status bit positions
	localparam int CTRL_WP     = 0;
	localparam int STS_BUSY    = 0;
	localparam int STS_FLT_D   = 1;
	localparam int STS_FLT_I   = 2;
	localparam int STS_LOCK    = 3;
	localparam int STS_LARGE   = 4;

	// Table entry bit positions
	localparam int ENT_P  = 0;
	localparam int ENT_W  = 1;
	localparam int ENT_U  = 2;
	localparam int ENT_WT = 3;
	localparam int ENT_CI = 4;
	localparam int ENT_A  = 5;
	localparam int ENT_D  = 6;
	localparam int ENT_PS = 7;

	// Frame fields and virtual address split
	localparam int BASE_LSB  = 12;
	localparam int BIG_LSB   = 22;
	localparam int DIR_LSB   = 22;
	localparam int MID_LSB   = 12;

	// AXI response codes
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Walk states, one-hot
	typedef enum logic [11:0] {
		ST_IDLE     = 12'h001,
		ST_RD_DIR   = 12'h002,
		ST_CHK_DIR  = 12'h004,
		ST_LRD_DIR  = 12'h008,
		ST_LCHK_DIR = 12'h010,
		ST_WR_DIR   = 12'h020,
		ST_DIR_DONE = 12'h040,
		ST_RD_TBL   = 12'h080,
		ST_CHK_TBL  = 12'h100,
		ST_LRD_TBL  = 12'h200,
		ST_LCHK_TBL = 12'h400,
		ST_WR_TBL   = 12'h800
	} tpw_state_type;

endpackage

// [rtl/tpw_walker.sv]
/*
 * Two-level page walker with protection checks, accessed-flag update
 * under bus lock, fault reporting and page attribute pins.
 * Assumes the core holds a translation request until req_ready_o, the
 * memory port holds its answer for one mem_ready_i cycle, and software
 * programs the directory base over AXI4-Lite. All inputs share sys_clk_i.
 */
`timescale 1ns/1ps

module tpw_walker #(
	parameter int AXI_ADDR_W = 8
) (
	// Clock and reset
	input  wire logic                  sys_clk_i,
	input  wire logic                  rst_i,
	// Translation request from fetch and load/store units
	input  wire logic                  req_valid_i,
	output logic                       req_ready_o,
	input  wire logic [31:0]           req_vaddr_i,
	input  wire logic                  req_write_i,
	input  wire logic                  req_instr_i,
	input  wire logic                  req_user_i,
	input  wire logic                  req_locked_i,
	// Translation answer
	output logic                       resp_valid_o,
	output logic [31:0]                resp_paddr_o,
	output logic                       resp_fault_data_o,
	output logic                       resp_fault_instr_o,
	output logic                       page_cache_inhibit_out_o,
	output logic                       page_write_through_out_o,
	// External memory port for table entries
	output logic                       mem_valid_o,
	input  wire logic                  mem_ready_i,
	output logic                       mem_write_o,
	output logic [31:0]                mem_addr_o,
	output logic [31:0]                mem_wdata_o,
	input  wire logic [31:0]           mem_rdata_i,
	output logic                       mem_lock_o,
	output logic                       mem_uncached_o,
	// AXI4-Lite register slave
	input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready
);

	if (AXI_ADDR_W < 4 || AXI_ADDR_W > 8)
		$error("tpw_walker: AXI_ADDR_W must lie in 4..8");

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Protection check of one entry: {fault, forced data fault}
	function automatic logic [1:0] perm_check(input logic [31:0] e, input logic wr,
		input logic usr, input logic wp);
		logic [1:0] r;
		r = 2'b00;
		if (!e[tpw_pkg::ENT_P])
			r = 2'b10;
		else if (!e[tpw_pkg::ENT_W] && wr && (usr || wp))
			r = 2'b11;
		else if (!e[tpw_pkg::ENT_U] && usr)
			r = 2'b10;
		return r;
	endfunction

	// Byte-lane merge for register writes
	function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Registers

	tpw_pkg::tpw_state_type st_q, st_d;
	logic [31:0] dirbase_q;
	logic        wp_q;
	logic [31:0] vaddr_q;
	logic        wr_q, instr_q, user_q, locked_q;
	logic [31:0] dir_q, dir_d, tbl_q, tbl_d;
	logic        was_clr_q, was_clr_d;
	logic        lock_q, lock_d;
	logic [31:0] maddr_q, maddr_d, mwdata_q, mwdata_d;
	logic        mwrite_q, mwrite_d;
	logic        fin_d, flt_d, fdata_d, large_d;
	logic [31:0] paddr_d;
	logic        pcd_d, pwt_d;
	logic        resp_valid_q, fdata_q, finstr_q, pcd_q, pwt_q, large_q;
	logic [31:0] paddr_q;

	////////////////////////////////////////////////////////////////////////////
	// Decodes

	// Byte 0 of the word sits in bits 7:0 whatever the data byte order
	wire logic [31:0] entry_rd  = mem_rdata_i;
	wire logic        mem_ack   = mem_valid_o && mem_ready_i;
	wire logic        take_req  = req_valid_i && req_ready_o;
	// Formed from the incoming request so the address register is right before the first read
	wire logic [31:0] dir_addr  = {dirbase_q[31:tpw_pkg::BASE_LSB],
		req_vaddr_i[31:tpw_pkg::DIR_LSB], 2'b00};
	wire logic [31:0] tbl_addr  = {dir_q[31:tpw_pkg::BASE_LSB],
		vaddr_q[tpw_pkg::DIR_LSB-1:tpw_pkg::MID_LSB], 2'b00};
	wire logic [1:0]  dir_chk   = perm_check(dir_q, wr_q, user_q, wp_q);
	// Table entry rights narrowed by the directory entry
	wire logic [31:0] tbl_eff   = {tbl_q[31:3],
		tbl_q[tpw_pkg::ENT_U] & dir_q[tpw_pkg::ENT_U],
		tbl_q[tpw_pkg::ENT_W] & dir_q[tpw_pkg::ENT_W], tbl_q[tpw_pkg::ENT_P]};
	wire logic [1:0]  tbl_chk   = perm_check(tbl_eff, wr_q, user_q, wp_q);
	wire logic [31:0] big_pa    = {dir_q[31:tpw_pkg::BIG_LSB],
		vaddr_q[tpw_pkg::BIG_LSB-1:0]};
	wire logic [31:0] small_pa  = {tbl_q[31:tpw_pkg::BASE_LSB],
		vaddr_q[tpw_pkg::BASE_LSB-1:0]};

	////////////////////////////////////////////////////////////////////////////
	// Walk state machine

	always_comb
	begin
		st_d      = st_q;
		dir_d     = dir_q;
		tbl_d     = tbl_q;
		was_clr_d = was_clr_q;
		lock_d    = lock_q;
		maddr_d   = maddr_q;
		mwdata_d  = mwdata_q;
		mwrite_d  = mwrite_q;
		fin_d     = 1'b0;
		flt_d     = 1'b0;
		fdata_d   = 1'b0;
		large_d   = 1'b0;
		paddr_d   = 32'h0000_0000;
		pcd_d     = 1'b0;
		pwt_d     = 1'b0;
		case (st_q)
			tpw_pkg::ST_IDLE:
				if (take_req)
				begin
					st_d     = tpw_pkg::ST_RD_DIR;
					mwrite_d = 1'b0;
					maddr_d  = dir_addr; // Address stands from the first valid cycle
					lock_d   = 1'b0; // A lock left by a locked table fault ends here
				end
			tpw_pkg::ST_RD_DIR, tpw_pkg::ST_LRD_DIR:
			begin
				if (mem_ack)
				begin
					dir_d = entry_rd;
					st_d  = (st_q == tpw_pkg::ST_RD_DIR) ? tpw_pkg::ST_CHK_DIR : tpw_pkg::ST_LCHK_DIR;
				end
			end
			tpw_pkg::ST_CHK_DIR:
			begin
				was_clr_d = !dir_q[tpw_pkg::ENT_A];
				if (dir_chk[1])
				begin
					flt_d   = 1'b1;
					fdata_d = dir_chk[0];
				end
				else if (!dir_q[tpw_pkg::ENT_A] && locked_q)
					flt_d = 1'b1;
				else if (dir_q[tpw_pkg::ENT_PS] && wr_q && !dir_q[tpw_pkg::ENT_D])
				begin
					flt_d   = 1'b1;
					fdata_d = 1'b1;
				end
				else if (!dir_q[tpw_pkg::ENT_A])
				begin
					lock_d = 1'b1;
					st_d   = tpw_pkg::ST_LRD_DIR;
				end
				else
					st_d = tpw_pkg::ST_DIR_DONE;
			end
			tpw_pkg::ST_LCHK_DIR:
				if (dir_chk[1])
				begin
					flt_d   = 1'b1;
					fdata_d = dir_chk[0];
				end
				else
				begin
					st_d     = tpw_pkg::ST_WR_DIR;
					mwrite_d = 1'b1;
					mwdata_d = dir_q | (32'h1 << tpw_pkg::ENT_A);
				end
			tpw_pkg::ST_WR_DIR:
				if (mem_ack)
				begin
					lock_d   = 1'b0;
					mwrite_d = 1'b0;
					st_d     = tpw_pkg::ST_DIR_DONE;
				end
			tpw_pkg::ST_DIR_DONE:
				if (dir_q[tpw_pkg::ENT_PS])
				begin
					fin_d   = 1'b1;
					large_d = 1'b1;
					paddr_d = big_pa;
					pcd_d   = dir_q[tpw_pkg::ENT_CI];
					pwt_d   = dir_q[tpw_pkg::ENT_WT];
				end
				else
				begin
					lock_d  = was_clr_q;
					maddr_d = tbl_addr;
					st_d    = tpw_pkg::ST_RD_TBL;
				end
			tpw_pkg::ST_RD_TBL, tpw_pkg::ST_LRD_TBL:
			begin
				if (mem_ack)
				begin
					tbl_d = entry_rd;
					st_d  = (st_q == tpw_pkg::ST_RD_TBL) ? tpw_pkg::ST_CHK_TBL : tpw_pkg::ST_LCHK_TBL;
				end
			end
			tpw_pkg::ST_CHK_TBL:
				if (tbl_chk[1])
				begin
					flt_d   = 1'b1;
					fdata_d = tbl_chk[0];
				end
				else if (!tbl_q[tpw_pkg::ENT_A] && locked_q)
				begin
					flt_d  = 1'b1;
					lock_d = 1'b1;
				end
				else if (wr_q && !tbl_q[tpw_pkg::ENT_D])
				begin
					flt_d   = 1'b1;
					fdata_d = 1'b1;
				end
				else if (!was_clr_q && tbl_q[tpw_pkg::ENT_A])
				begin
					fin_d   = 1'b1;
					paddr_d = small_pa;
					pcd_d   = tbl_q[tpw_pkg::ENT_CI];
					pwt_d   = tbl_q[tpw_pkg::ENT_WT];
				end
				else if (!lock_q)
				begin
					lock_d = 1'b1;
					st_d   = tpw_pkg::ST_LRD_TBL;
				end
				else
					st_d = tpw_pkg::ST_LCHK_TBL;
			tpw_pkg::ST_LCHK_TBL:
				if (tbl_chk[1])
				begin
					flt_d   = 1'b1;
					fdata_d = tbl_chk[0];
				end
				else
				begin
					st_d     = tpw_pkg::ST_WR_TBL;
					mwrite_d = 1'b1;
					mwdata_d = tbl_q | (32'h1 << tpw_pkg::ENT_A);
				end
			tpw_pkg::ST_WR_TBL:
				if (mem_ack)
				begin
					lock_d   = 1'b0;
					mwrite_d = 1'b0;
					fin_d    = 1'b1;
					paddr_d  = small_pa;
					pcd_d    = tbl_q[tpw_pkg::ENT_CI];
					pwt_d    = tbl_q[tpw_pkg::ENT_WT];
				end
			default:
				st_d = tpw_pkg::ST_IDLE;
		endcase
		// A fault ends the walk; the locked table-accessed fault keeps the lock
		if (flt_d)
		begin
			fin_d = 1'b1;
			st_d  = tpw_pkg::ST_IDLE;
			if (!(st_q == tpw_pkg::ST_CHK_TBL && !tbl_chk[1] && locked_q && !tbl_q[tpw_pkg::ENT_A]))
				lock_d = 1'b0;
		end
		if (fin_d)
			st_d = tpw_pkg::ST_IDLE;
	end

	// Walk registers
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			st_q      <= tpw_pkg::ST_IDLE;
			dir_q     <= 32'h0000_0000;
			tbl_q     <= 32'h0000_0000;
			was_clr_q <= 1'b0;
			lock_q    <= 1'b0;
			maddr_q   <= 32'h0000_0000;
			mwdata_q  <= 32'h0000_0000;
			mwrite_q  <= 1'b0;
		end
		else
		begin
			st_q      <= st_d;
			dir_q     <= dir_d;
			tbl_q     <= tbl_d;
			was_clr_q <= was_clr_d;
			lock_q    <= lock_d;
			maddr_q   <= maddr_d;
			mwdata_q  <= mwdata_d;
			mwrite_q  <= mwrite_d;
		end
	end

	// Request capture; the reference is frozen for the whole walk
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			vaddr_q  <= 32'h0000_0000;
			wr_q     <= 1'b0;
			instr_q  <= 1'b0;
			user_q   <= 1'b0;
			locked_q <= 1'b0;
		end
		else if (take_req)
		begin
			vaddr_q  <= req_vaddr_i;
			wr_q     <= req_write_i;
			instr_q  <= req_instr_i;
			user_q   <= req_user_i;
			locked_q <= req_locked_i;
		end
	end

	// Answer registers; attribute pins hold until the next translation without a fault ends
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			resp_valid_q <= 1'b0;
			fdata_q      <= 1'b0;
			finstr_q     <= 1'b0;
			paddr_q      <= 32'h0000_0000;
			pcd_q        <= 1'b0;
			pwt_q        <= 1'b0;
			large_q      <= 1'b0;
		end
		else
		begin
			resp_valid_q <= fin_d;
			if (fin_d)
			begin
				fdata_q  <= flt_d && (fdata_d || !instr_q);
				finstr_q <= flt_d && !fdata_d && instr_q;
				large_q  <= large_d;
				if (!flt_d)
				begin
					paddr_q <= paddr_d;
					pcd_q   <= pcd_d;
					pwt_q   <= pwt_d;
				end
			end
		end
	end

	// Memory and core side outputs
	assign req_ready_o              = (st_q == tpw_pkg::ST_IDLE);
	assign resp_valid_o             = resp_valid_q;
	assign resp_paddr_o             = paddr_q;
	assign resp_fault_data_o        = fdata_q && resp_valid_q;
	assign resp_fault_instr_o       = finstr_q && resp_valid_q;
	assign page_cache_inhibit_out_o = pcd_q;
	assign page_write_through_out_o = pwt_q;
	assign mem_valid_o              = (st_q == tpw_pkg::ST_RD_DIR) || (st_q == tpw_pkg::ST_LRD_DIR)
		|| (st_q == tpw_pkg::ST_WR_DIR) || (st_q == tpw_pkg::ST_RD_TBL)
		|| (st_q == tpw_pkg::ST_LRD_TBL) || (st_q == tpw_pkg::ST_WR_TBL);
	assign mem_write_o              = mwrite_q;
	assign mem_addr_o               = maddr_q;
	assign mem_wdata_o              = mwdata_q;
	assign mem_lock_o               = lock_q;
	assign mem_uncached_o           = mem_valid_o;

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave

	logic                  aw_got_q, w_got_q, bvalid_q, rvalid_q;
	logic [AXI_ADDR_W-1:0] awaddr_q;
	logic [31:0]           wdata_q, rdata_q;
	logic [3:0]            wstrb_q;
	logic [1:0]            bresp_q, rresp_q;

	// Address decode; only the low byte of the address selects a register
	wire logic [7:0] wa8     = 8'(awaddr_q);
	wire logic [7:0] ra8     = 8'(s_axi_araddr);
	wire logic       do_wr   = aw_got_q && w_got_q && !bvalid_q;
	wire logic       wr_base = do_wr && (wa8 == tpw_pkg::OFS_DIRBASE);
	wire logic       wr_ctrl = do_wr && (wa8 == tpw_pkg::OFS_CTRL);
	wire logic       wr_ok   = (wa8 == tpw_pkg::OFS_DIRBASE) || (wa8 == tpw_pkg::OFS_CTRL);
	wire logic       rd_hs   = s_axi_arvalid && s_axi_arready;
	wire logic [31:0] status = {27'h0, large_q, lock_q, finstr_q, fdata_q, !req_ready_o};
	logic [31:0] rd_mux;
	logic        rd_ok;

	// Read decode; unmapped offsets read zero with an error answer
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		rd_ok  = 1'b1;
		if (ra8 == tpw_pkg::OFS_DIRBASE)
			rd_mux = dirbase_q;
		else if (ra8 == tpw_pkg::OFS_CTRL)
			rd_mux = {31'h0, wp_q};
		else if (ra8 == tpw_pkg::OFS_STATUS)
			rd_mux = status;
		else if (ra8 == tpw_pkg::OFS_PADDR)
			rd_mux = paddr_q;
		else
			rd_ok = 1'b0;
	end

	// Write channels are taken in either order, answered once both are in
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			aw_got_q <= 1'b0;
			w_got_q  <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q  <= tpw_pkg::RESP_OKAY;
			awaddr_q <= '0;
			wdata_q  <= 32'h0000_0000;
			wstrb_q  <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_wr)
			begin
				aw_got_q <= 1'b0;
				w_got_q  <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q  <= wr_ok ? tpw_pkg::RESP_OKAY : tpw_pkg::RESP_SLVERR;
			end
			else if (s_axi_bready)
				bvalid_q <= 1'b0;
		end
	end

	// Software registers; the base may change mid walk, taking effect next walk
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			dirbase_q <= tpw_pkg::RST_DIRBASE;
			wp_q      <= tpw_pkg::RST_WP;
		end
		else
		begin
			if (wr_base)
				dirbase_q <= lane_merge(dirbase_q, wdata_q, wstrb_q) & 32'hffff_f000;
			if (wr_ctrl && wstrb_q[0])
				wp_q <= wdata_q[tpw_pkg::CTRL_WP];
		end
	end

	// Read channel
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= tpw_pkg::RESP_OKAY;
		end
		else if (rd_hs)
		begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_mux;
			rresp_q  <= rd_ok ? tpw_pkg::RESP_OKAY : tpw_pkg::RESP_SLVERR;
		end
		else if (s_axi_rready)
			rvalid_q <= 1'b0;
	end

	assign s_axi_awready = !aw_got_q && !bvalid_q;
	assign s_axi_wready  = !w_got_q && !bvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

endmodule // tpw_walker
